// ==== plc_event_window.sv ====
// counts one kind of error event inside the fast link-down window
module plc_event_window (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic window_start_i,
  input wire logic enable_i,
  input wire logic event_i,
  input wire logic [5:0] limit_i,
  output logic trip_o
);
  logic [5:0] count;
  logic [5:0] next_count;
  logic next_trip;

  always_comb begin
    next_count = count;
    next_trip = 1'b0;
    if (window_start_i || !enable_i) begin
      next_count = 6'h00;
    end else if (event_i && count != limit_i) begin
      next_count = count + 6'h01;
      next_trip = (count + 6'h01) == limit_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      count <= 6'h00;
      trip_o <= 1'b0;
    end else begin
      count <= next_count;
      trip_o <= next_trip;
    end
  end
endmodule // plc_event_window

// ==== plc_link_control.sv ====
// link-level control: squelch, collision, carrier, jabber, negotiation, fast link-down
// Contract
// - qualify 10M input: threshold, opposite after 50 ns, original after 50 ns more.
// - while transmitting, need five consecutive valid transitions before receive is valid.
// - 10M half duplex collision during tx/rx overlap, raised at once.
// - half duplex carrier on tx or rx; full duplex only qualified rx.
// - carrier drops at end of packet.
// - 10M only jabber timer disables transmit after about 100 ms.
// - after jabber, re-enable only after enable low 500 ms continuously.
// - 10M detects reversed polarity and corrects it; none for 100M.
// - 10M full duplex never asserts collision.
// - strap-enabled negotiation starts on reset release, soft reset, bit 9, bit 11.
// - with bit 12 set, negotiation starts on soft restart or link fail.
// - bit 12 change takes effect only after restart bit 9 write.
// - straps force modes when strap low, choose advertised sets when high.
// - straps latched into negotiation registers during hardware or software reset.
// - next pages sent from 0x7, received into 0x8, flagged in expansion bit 1.
// - each next page waits for transmit page write; received page read first.
// - 32 receive errors in 10 us drop the link when enabled.
// - 20 code violations in 10 us drop the link when enabled.
// - 20 low-quality crossings in 10 us drop the link when enabled.
// - energy loss drops link at once when enabled.
module plc_link_control (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic negotiation_enable_strap_i,
  input wire logic mode_select_strap_hi_i,
  input wire logic mode_select_strap_lo_i,
  input wire logic squelch_pos_i,
  input wire logic squelch_neg_i,
  input wire logic rx_end_i,
  input wire logic tx_en_i,
  input wire logic rx_error_i,
  input wire logic code_violation_i,
  input wire logic low_quality_i,
  input wire logic energy_loss_i,
  input wire logic link_fail_i,
  input wire logic partner_page_valid_i,
  input wire logic [15:0] partner_page_i,
  input wire logic page_sent_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic crs_o,
  output logic col_o,
  output logic tx_enable_o,
  output logic polarity_inverted_o,
  output logic rx_valid_o,
  output logic speed_100_o,
  output logic full_duplex_o,
  output logic neg_start_o,
  output logic page_send_o,
  output logic [15:0] page_data_o,
  output logic link_drop_o
);
  // squelch, end-of-packet and energy-loss pins through two flip-flops
  logic [1:0] pos_sync, neg_sync, end_sync, eloss_sync;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pos_sync <= 2'h0;
      neg_sync <= 2'h0;
      end_sync <= 2'h0;
      eloss_sync <= 2'h0;
    end else begin
      pos_sync <= {pos_sync[0], squelch_pos_i};
      neg_sync <= {neg_sync[0], squelch_neg_i};
      end_sync <= {end_sync[0], rx_end_i};
      eloss_sync <= {eloss_sync[0], energy_loss_i};
    end
  end
  logic sq_pos, sq_neg, rx_end, eloss;
  assign sq_pos = pos_sync[1];
  assign sq_neg = neg_sync[1];
  assign rx_end = end_sync[1];
  assign eloss = eloss_sync[1];

  // registers
  logic [15:0] bmc, adv, npt, lnp, strap3;
  logic page_rx, page_pending, neg_pending, hw_started, soft_rst_d;
  logic [15:0] next_bmc, next_adv, next_npt, next_lnp, next_strap3;
  logic next_page_rx, next_page_pending, next_neg_pending, next_hw_started;
  logic soft_rst;
  assign soft_rst = reg_wr_i && reg_addr_i == plc_pkg::ADDR_BASIC_MODE_CONTROL
                    && reg_wdata_i[plc_pkg::BMC_RESET_BIT];

  function automatic logic [15:0] strap_adv(input logic hi, input logic lo);
    unique case ({hi, lo})
      2'b00: strap_adv = plc_pkg::ADV_10_HALF | plc_pkg::ADV_10_FULL;
      2'b01: strap_adv = plc_pkg::ADV_100_HALF | plc_pkg::ADV_100_FULL;
      2'b10: strap_adv = plc_pkg::ADV_10_HALF | plc_pkg::ADV_100_HALF;
      2'b11: strap_adv = plc_pkg::ADV_10_HALF | plc_pkg::ADV_10_FULL
                         | plc_pkg::ADV_100_HALF | plc_pkg::ADV_100_FULL;
    endcase
  endfunction

  // straps taken in the first cycle after reset release or after a soft reset write
  function automatic logic [15:0] strap_bmc(input logic en, input logic hi, input logic lo);
    strap_bmc = 16'h0000;
    strap_bmc[plc_pkg::BMC_NEG_EN_BIT] = en;
    strap_bmc[plc_pkg::BMC_SPEED_BIT] = !en && hi;
    strap_bmc[plc_pkg::BMC_DUPLEX_BIT] = !en && lo;
  endfunction

  logic neg_en_active; // bit 12 as last acted upon
  logic next_neg_en_active;
  logic restart_wr;
  assign restart_wr = reg_wr_i && reg_addr_i == plc_pkg::ADDR_BASIC_MODE_CONTROL
                      && reg_wdata_i[plc_pkg::BMC_RESTART_BIT];

  always_comb begin
    next_bmc = bmc;
    next_adv = adv;
    next_npt = npt;
    next_lnp = lnp;
    next_strap3 = strap3;
    next_page_rx = page_rx;
    next_page_pending = page_pending;
    next_neg_pending = 1'b0;
    next_hw_started = 1'b1;
    next_neg_en_active = neg_en_active;
    if (!hw_started || soft_rst_d) begin
      next_bmc = strap_bmc(negotiation_enable_strap_i, mode_select_strap_hi_i,
                           mode_select_strap_lo_i);
      next_adv = plc_pkg::ADV_RESET_VALUE
                 | strap_adv(mode_select_strap_hi_i, mode_select_strap_lo_i);
      next_npt = plc_pkg::NEXT_PAGE_RESET_VALUE;
      next_neg_en_active = negotiation_enable_strap_i;
      next_neg_pending = negotiation_enable_strap_i;
      next_page_rx = 1'b0;
      next_page_pending = 1'b0;
    end else begin
      // consuming the old page must not cancel a fresh write in the same cycle
      if (page_sent_i) begin
        next_page_pending = 1'b0;
      end
      if (reg_wr_i) begin
        unique case (reg_addr_i)
          plc_pkg::ADDR_BASIC_MODE_CONTROL: next_bmc = reg_wdata_i
                                            & ~(16'h0001 << plc_pkg::BMC_RESTART_BIT);
          plc_pkg::ADDR_NEGOTIATION_ADVERTISEMENT: next_adv = reg_wdata_i;
          plc_pkg::ADDR_NEXT_PAGE_TRANSMIT: begin
            next_npt = reg_wdata_i;
            next_page_pending = 1'b1;
          end
          plc_pkg::ADDR_SOFTWARE_STRAP_CONTROL_THREE: next_strap3 = reg_wdata_i;
          default: next_bmc = bmc;
        endcase
      end
      if (restart_wr) begin
        next_neg_en_active = reg_wdata_i[plc_pkg::BMC_NEG_EN_BIT];
        next_neg_pending = reg_wdata_i[plc_pkg::BMC_NEG_EN_BIT] || neg_en_active;
      end
      // power-up: clearing bit 11 restarts negotiation
      if (reg_wr_i && reg_addr_i == plc_pkg::ADDR_BASIC_MODE_CONTROL
          && bmc[plc_pkg::BMC_POWER_DOWN_BIT] && !reg_wdata_i[plc_pkg::BMC_POWER_DOWN_BIT]
          && neg_en_active) begin
        next_neg_pending = 1'b1;
      end
      if (link_fail_i && neg_en_active) begin
        next_neg_pending = 1'b1;
      end
      if (reg_rd_i && reg_addr_i == plc_pkg::ADDR_NEGOTIATION_EXPANSION) begin
        next_page_rx = 1'b0;
      end
      // a new page only overwrites while no written transmit page is still waiting to be sent
      if (partner_page_valid_i && !page_pending) begin
        next_lnp = partner_page_i;
        next_page_rx = 1'b1; // set wins over read clear
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      bmc <= 16'h0000;
      adv <= plc_pkg::ADV_RESET_VALUE;
      npt <= plc_pkg::NEXT_PAGE_RESET_VALUE;
      lnp <= 16'h0000;
      strap3 <= plc_pkg::STRAP3_RESET_VALUE;
      page_rx <= 1'b0;
      page_pending <= 1'b0;
      neg_pending <= 1'b0;
      hw_started <= 1'b0;
      soft_rst_d <= 1'b0;
      neg_en_active <= 1'b0;
    end else begin
      bmc <= next_bmc;
      adv <= next_adv;
      npt <= next_npt;
      lnp <= next_lnp;
      strap3 <= next_strap3;
      page_rx <= next_page_rx;
      page_pending <= next_page_pending;
      neg_pending <= next_neg_pending;
      hw_started <= next_hw_started;
      soft_rst_d <= soft_rst;
      neg_en_active <= next_neg_en_active;
    end
  end

  // register read mux
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = 16'h0000;
    unique case (reg_addr_i)
      plc_pkg::ADDR_BASIC_MODE_CONTROL: next_rdata = bmc;
      plc_pkg::ADDR_NEGOTIATION_ADVERTISEMENT: next_rdata = adv;
      plc_pkg::ADDR_NEGOTIATION_EXPANSION: next_rdata[plc_pkg::EXP_PAGE_RECEIVED_BIT] = page_rx;
      plc_pkg::ADDR_NEXT_PAGE_TRANSMIT: next_rdata = npt;
      plc_pkg::ADDR_PARTNER_NEXT_PAGE_RECEIVE: next_rdata = lnp;
      plc_pkg::ADDR_SOFTWARE_STRAP_CONTROL_THREE: next_rdata = strap3;
      default: next_rdata = 16'h0000;
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  assign speed_100_o = bmc[plc_pkg::BMC_SPEED_BIT];
  assign full_duplex_o = bmc[plc_pkg::BMC_DUPLEX_BIT];
  assign neg_start_o = neg_pending;
  assign page_data_o = npt;
  // without next-page mode the engine never waits on software
  assign page_send_o = page_pending || !adv[plc_pkg::ADV_NEXT_PAGE_BIT];
  logic is_10m;
  assign is_10m = !speed_100_o;

  // squelch qualification, polarity taken from the first threshold crossed
  plc_pkg::plc_qual_type qual, next_qual;
  logic first_pos, next_first_pos, pol_inv, next_pol_inv;
  logic [3:0] gap, next_gap;
  logic [2:0] trans, next_trans;
  logic last_lvl, next_last_lvl;
  logic orig_hit, opp_hit;
  assign orig_hit = first_pos ? sq_pos : sq_neg;
  assign opp_hit = first_pos ? sq_neg : sq_pos;

  always_comb begin
    next_qual = qual;
    next_first_pos = first_pos;
    next_pol_inv = pol_inv;
    next_gap = (gap == 4'hF) ? gap : gap + 4'h1;
    next_trans = trans;
    next_last_lvl = last_lvl;
    if (!is_10m || rx_end) begin
      next_qual = plc_pkg::QUAL_IDLE;
      next_trans = 3'h0;
    end else begin
      unique case (qual)
        plc_pkg::QUAL_IDLE: if (sq_pos || sq_neg) begin
          next_first_pos = sq_pos;
          next_qual = plc_pkg::QUAL_FIRST;
          next_gap = 4'h0;
        end
        plc_pkg::QUAL_FIRST: if (opp_hit && gap >= 4'(plc_pkg::QUAL_GAP_CYCLES - 1)) begin
          next_qual = plc_pkg::QUAL_OPPOSITE;
          next_gap = 4'h0;
        end else if (opp_hit) begin
          next_qual = plc_pkg::QUAL_IDLE; // too early: rejected
        end
        plc_pkg::QUAL_OPPOSITE: if (orig_hit && gap >= 4'(plc_pkg::QUAL_GAP_CYCLES - 1)) begin
          next_qual = plc_pkg::QUAL_VALID;
          next_pol_inv = !first_pos; // preamble starts positive
          next_trans = 3'h0;
          next_last_lvl = sq_pos;
        end else if (orig_hit) begin
          next_qual = plc_pkg::QUAL_IDLE;
        end
        plc_pkg::QUAL_VALID: if (sq_pos != last_lvl) begin
          next_last_lvl = sq_pos;
          if (trans != 3'(plc_pkg::RX_BUSY_TRANSITIONS)) next_trans = trans + 3'h1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      qual <= plc_pkg::QUAL_IDLE;
      first_pos <= 1'b1;
      pol_inv <= 1'b0;
      gap <= 4'h0;
      trans <= 3'h0;
      last_lvl <= 1'b0;
    end else begin
      qual <= next_qual;
      first_pos <= next_first_pos;
      pol_inv <= next_pol_inv;
      gap <= next_gap;
      trans <= next_trans;
      last_lvl <= next_last_lvl;
    end
  end
  assign polarity_inverted_o = pol_inv && is_10m;

  logic rx_active;
  assign rx_active = qual == plc_pkg::QUAL_VALID
                     && (!tx_en_i || trans == 3'(plc_pkg::RX_BUSY_TRANSITIONS));
  assign rx_valid_o = rx_active;
  assign col_o = is_10m && !full_duplex_o && tx_en_i && rx_active;
  assign crs_o = full_duplex_o ? rx_active : (rx_active || tx_en_i);

  // jabber: one 27-bit counter holds both 100 ms and 500 ms counts
  logic jabbed, next_jabbed;
  logic [26:0] jab_cnt, next_jab_cnt;
  always_comb begin
    next_jabbed = jabbed;
    next_jab_cnt = jab_cnt;
    if (!is_10m) begin
      next_jabbed = 1'b0;
      next_jab_cnt = 27'h0;
    end else if (!jabbed) begin
      next_jab_cnt = tx_en_i ? jab_cnt + 27'h1 : 27'h0;
      if (tx_en_i && jab_cnt == 27'(plc_pkg::JABBER_CYCLES - 1)) begin
        next_jabbed = 1'b1;
        next_jab_cnt = 27'h0;
      end
    end else begin
      next_jab_cnt = tx_en_i ? 27'h0 : jab_cnt + 27'h1;
      if (!tx_en_i && jab_cnt == 27'(plc_pkg::UNJAB_CYCLES - 1)) begin
        next_jabbed = 1'b0;
        next_jab_cnt = 27'h0;
      end
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      jabbed <= 1'b0;
      jab_cnt <= 27'h0;
    end else begin
      jabbed <= next_jabbed;
      jab_cnt <= next_jab_cnt;
    end
  end
  assign tx_enable_o = tx_en_i && !jabbed;

  // fast link-down window
  logic [9:0] win, next_win;
  logic win_start;
  assign win_start = win == 10'h000;
  assign next_win = (win == 10'(plc_pkg::FLD_WINDOW_CYCLES - 1)) ? 10'h000 : win + 10'h001;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) win <= 10'h000;
    else win <= next_win;
  end
  logic [2:0] trip;
  logic [2:0] fld_event;
  logic [5:0] fld_limit [3];
  assign fld_event = {low_quality_i, code_violation_i, rx_error_i};
  assign fld_limit[0] = plc_pkg::FLD_RX_ERR_LIMIT;
  assign fld_limit[1] = plc_pkg::FLD_CODE_VIOL_LIMIT;
  assign fld_limit[2] = plc_pkg::FLD_LOW_QUALITY_LIMIT;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_fld
      plc_event_window u_win (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .window_start_i(win_start),
        .enable_i(strap3[g]),
        .event_i(fld_event[g]),
        .limit_i(fld_limit[g]),
        .trip_o(trip[g])
      );
    end
  endgenerate
  assign link_drop_o = (|trip) || (strap3[plc_pkg::FLD_ENERGY_LOSS_BIT] && eloss);
endmodule // plc_link_control

// ==== plc_link_control_asserts.sv ====
// concurrent checks on the link control ports
module plc_link_control_asserts (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic negotiation_enable_strap_i,
  input wire logic energy_loss_i,
  input wire logic tx_en_i,
  input wire logic page_sent_i,
  input wire logic reg_wr_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic crs_o,
  input wire logic col_o,
  input wire logic speed_100_o,
  input wire logic full_duplex_o,
  input wire logic neg_start_o,
  input wire logic page_send_o,
  input wire logic [15:0] page_data_o,
  input wire logic link_drop_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // shadow of the link-down enables; soft reset leaves that register alone
  logic [3:0] fld_en;
  logic [3:0] next_fld_en;
  always_comb begin
    next_fld_en = fld_en;
    if (reg_wr_i && reg_addr_i == plc_pkg::ADDR_SOFTWARE_STRAP_CONTROL_THREE) begin
      next_fld_en = reg_wdata_i[3:0];
    end
  end
  always_ff @(posedge sys_clk_i) begin
    fld_en <= rst_n_i ? next_fld_en : 4'h0;
  end
  sequence s_release;
    $rose(rst_n_i) && negotiation_enable_strap_i;
  endsequence
  sequence s_page_wr;
    reg_wr_i && reg_addr_i == plc_pkg::ADDR_NEXT_PAGE_TRANSMIT;
  endsequence
  a_neg_on_release: assert property (
    s_release |-> ##[1:3] neg_start_o)
    else $error("no negotiation start after reset release");
  a_neg_one_pulse: assert property (
    neg_start_o |=> !neg_start_o)
    else $error("negotiation start longer than one cycle");
  a_col_full_dup: assert property (
    full_duplex_o |-> !col_o)
    else $error("collision in full duplex");
  a_col_cause: assert property (
    col_o |-> tx_en_i && !speed_100_o && !full_duplex_o)
    else $error("collision without 10M half duplex transmit");
  a_crs_half_tx: assert property (
    tx_en_i && !full_duplex_o && !speed_100_o |-> ##[0:2] crs_o)
    else $error("no carrier while transmitting in half duplex");
  a_page_load: assert property (
    s_page_wr |=> page_send_o && page_data_o == $past(reg_wdata_i))
    else $error("transmit page not offered after write");
  a_page_hold: assert property (
    page_send_o && !page_sent_i && !reg_wr_i |=> page_send_o)
    else $error("transmit page withdrawn before it was sent");
  a_energy_drop: assert property (
    energy_loss_i && fld_en[3] |-> ##[0:4] link_drop_o)
    else $error("energy loss did not drop the link");
  a_drop_enabled: assert property (
    link_drop_o |-> fld_en != 4'h0)
    else $error("link dropped with no criterion enabled");
endmodule // plc_link_control_asserts

bind plc_link_control plc_link_control_asserts plc_link_control_asserts_i (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .energy_loss_i(energy_loss_i),
  .negotiation_enable_strap_i(negotiation_enable_strap_i), .tx_en_i(tx_en_i),
  .page_sent_i(page_sent_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .crs_o(crs_o), .col_o(col_o), .speed_100_o(speed_100_o),
  .full_duplex_o(full_duplex_o), .neg_start_o(neg_start_o), .page_send_o(page_send_o),
  .page_data_o(page_data_o), .link_drop_o(link_drop_o));

// ==== plc_partner.sv ====
// cable-side partner: squelch bursts, partner pages and page consumption
module plc_partner (
  input wire logic sys_clk_i,
  input wire logic page_send_i,
  input wire logic [7:0] lat_i,
  output logic squelch_pos_o,
  output logic squelch_neg_o,
  output logic page_valid_o,
  output logic [15:0] page_o,
  output logic page_sent_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int wait_cnt = 0;
  initial begin
    squelch_pos_o = 1'h0;
    squelch_neg_o = 1'h0;
    page_valid_o = 1'h0;
    page_o = 16'h0000;
    page_sent_o = 1'h0;
  end
  // engine takes the offered page after lat_i cycles, prompt or slow
  always @(posedge sys_clk_i) begin
    page_sent_o <= 1'h0;
    if (page_send_i && !page_sent_o) begin
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt >= lat_i) begin
        page_sent_o <= 1'h1;
        wait_cnt <= 0;
      end
    end
  end
  // gap below five cycles breaks the minimum spacing on purpose
  task automatic burst(input logic inv, input int gap, input int n);
    for (int i = 0; i < n + 3; i++) begin
      squelch_pos_o = ~(i[0] ^ inv);
      squelch_neg_o = i[0] ^ inv;
      repeat (gap) @(posedge sys_clk_i);
      #1;
    end
    squelch_pos_o = 1'h0;
    squelch_neg_o = 1'h0;
  endtask
  task automatic send_page(input logic [15:0] v);
    page_o = v;
    page_valid_o = 1'h1;
    @(posedge sys_clk_i);
    #1;
    page_valid_o = 1'h0;
    page_o = ~v;
  endtask
endmodule // plc_partner

// ==== plc_pkg.sv ====
// shared constants and types for the link control block
package plc_pkg;
  // register offsets (management register index)
  localparam logic [4:0] ADDR_BASIC_MODE_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_NEGOTIATION_ADVERTISEMENT = 5'h04;
  localparam logic [4:0] ADDR_NEGOTIATION_EXPANSION = 5'h06;
  localparam logic [4:0] ADDR_NEXT_PAGE_TRANSMIT = 5'h07;
  localparam logic [4:0] ADDR_PARTNER_NEXT_PAGE_RECEIVE = 5'h08;
  localparam logic [4:0] ADDR_SOFTWARE_STRAP_CONTROL_THREE = 5'h0B;
  // field positions
  localparam int BMC_RESET_BIT = 15;
  localparam int BMC_SPEED_BIT = 13;
  localparam int BMC_NEG_EN_BIT = 12;
  localparam int BMC_POWER_DOWN_BIT = 11;
  localparam int BMC_RESTART_BIT = 9;
  localparam int BMC_DUPLEX_BIT = 8;
  localparam int ADV_NEXT_PAGE_BIT = 15;
  localparam int EXP_PAGE_RECEIVED_BIT = 1;
  localparam int FLD_RX_ERR_BIT = 0;
  localparam int FLD_CODE_VIOL_BIT = 1;
  localparam int FLD_LOW_QUALITY_BIT = 2;
  localparam int FLD_ENERGY_LOSS_BIT = 3;
  // reset values
  localparam logic [15:0] ADV_RESET_VALUE = 16'h0001;
  localparam logic [15:0] NEXT_PAGE_RESET_VALUE = 16'h2001;
  localparam logic [15:0] STRAP3_RESET_VALUE = 16'h0000;
  // advertisement ability bits
  localparam logic [15:0] ADV_10_HALF = 16'h0020;
  localparam logic [15:0] ADV_10_FULL = 16'h0040;
  localparam logic [15:0] ADV_100_HALF = 16'h0080;
  localparam logic [15:0] ADV_100_FULL = 16'h0100;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int QUAL_GAP_NS = 50;
  localparam int QUAL_GAP_CYCLES = (QUAL_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int JABBER_MS = 100;
  localparam int UNJAB_MS = 500;
  localparam int JABBER_CYCLES = JABBER_MS * 1000000 / CLK_PERIOD_NS;
  localparam int UNJAB_CYCLES = UNJAB_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FLD_WINDOW_US = 10;
  localparam int FLD_WINDOW_CYCLES = FLD_WINDOW_US * 1000 / CLK_PERIOD_NS;
  localparam int RX_BUSY_TRANSITIONS = 5;
  localparam logic [5:0] FLD_RX_ERR_LIMIT = 6'd32;
  localparam logic [5:0] FLD_CODE_VIOL_LIMIT = 6'd20;
  localparam logic [5:0] FLD_LOW_QUALITY_LIMIT = 6'd20;
  typedef enum logic [1:0] {QUAL_IDLE, QUAL_FIRST, QUAL_OPPOSITE, QUAL_VALID} plc_qual_type;
endpackage : plc_pkg

// ==== testbench.sv ====
// self-checking bench for the link control block
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [4:0] A_BMC = plc_pkg::ADDR_BASIC_MODE_CONTROL;
  localparam logic [4:0] A_ADV = plc_pkg::ADDR_NEGOTIATION_ADVERTISEMENT;
  localparam logic [4:0] A_EXP = plc_pkg::ADDR_NEGOTIATION_EXPANSION;
  localparam logic [4:0] A_NPT = plc_pkg::ADDR_NEXT_PAGE_TRANSMIT;
  localparam logic [4:0] A_LNP = plc_pkg::ADDR_PARTNER_NEXT_PAGE_RECEIVE;
  localparam logic [4:0] A_SW3 = plc_pkg::ADDR_SOFTWARE_STRAP_CONTROL_THREE;
  logic sys_clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic s_en = 1'h1, s_hi = 1'h1, s_lo = 1'h1, rx_end = 1'h0, tx_en = 1'h0;
  logic rx_err = 1'h0, viol = 1'h0, lowq = 1'h0, eloss = 1'h0, lfail = 1'h0;
  logic wr = 1'h0, rd = 1'h0, rd_q = 1'h0;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic [7:0] lat = 8'h02;
  logic sq_p, sq_n, pg_v, pg_sent, crs, col, txo, pol, rxv, s100, fd, neg, psend, drop;
  logic [15:0] pg, rdata, pdata, v;
  logic [4:0] seen = 5'h00;
  logic [31:0] q[$];
  int n_mismatch = 0;
  int tests_run = 0;
  int lim;
  always #5 sys_clk_i = ~sys_clk_i;
  plc_link_control plc_link_control_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .negotiation_enable_strap_i(s_en), .mode_select_strap_hi_i(s_hi),
    .mode_select_strap_lo_i(s_lo), .squelch_pos_i(sq_p), .squelch_neg_i(sq_n),
    .rx_end_i(rx_end), .tx_en_i(tx_en), .rx_error_i(rx_err), .code_violation_i(viol),
    .low_quality_i(lowq), .energy_loss_i(eloss), .link_fail_i(lfail),
    .partner_page_valid_i(pg_v), .partner_page_i(pg), .page_sent_i(pg_sent),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .crs_o(crs), .col_o(col), .tx_enable_o(txo),
    .polarity_inverted_o(pol), .rx_valid_o(rxv), .speed_100_o(s100),
    .full_duplex_o(fd), .neg_start_o(neg), .page_send_o(psend), .page_data_o(pdata),
    .link_drop_o(drop));
  plc_partner plc_partner_i (.sys_clk_i(sys_clk_i), .page_send_i(psend), .lat_i(lat),
    .squelch_pos_o(sq_p), .squelch_neg_o(sq_n), .page_valid_o(pg_v), .page_o(pg),
    .page_sent_o(pg_sent));
  task automatic finish_test();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  // steps the clock and remembers short pulses for later checks
  task automatic run(input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      #1;
      seen = seen | {rxv, crs, col, drop, neg};
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    addr = a;
    wdata = d;
    wr = 1'h1;
    run(1);
    wr = 1'h0;
    run(1);
  endtask
  task automatic rd_reg(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
    q.push_back({e, m});
    addr = a;
    rd = 1'h1;
    run(1);
    rd = 1'h0;
    run(1);
  endtask
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      {lowq, viol, rx_err} = 3'h1 << k;
      run(1);
    end
    {lowq, viol, rx_err} = 3'h0;
  endtask
  task automatic burst_run(input logic inv, input int gap);
    fork
      plc_partner_i.burst(inv, gap, 8);
      run(12 * gap);
    join
  endtask
  // read data arrives one cycle after the address; oldest note is the expectation
  always @(posedge sys_clk_i) rd_q <= rd;
  always @(negedge sys_clk_i) begin
    if (rd_q) begin
      check(rdata & q[0][15:0], q[0][31:16]);
      void'(q.pop_front());
    end
  end
  initial begin
    #400000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h36EB));
    repeat (6) @(posedge sys_clk_i);
    #1;
    rst_n_i = 1'h1;
    run(3);
    check(seen[0], 1'h1);
    rd_reg(A_ADV, 16'h01E1, 16'hFFFF);
    rd_reg(A_NPT, 16'h2001, 16'hFFFF);
    rd_reg(A_SW3, 16'h0000, 16'hFFFF);
    rd_reg(5'h1F, 16'h0000, 16'hFFFF);
    seen = 5'h00;
    wr_reg(A_BMC, 16'h8000);
    run(4);
    check(seen[0], 1'h1);
    seen = 5'h00;
    wr_reg(A_BMC, 16'h1200);
    run(3);
    check(seen[0], 1'h1);
    wr_reg(A_BMC, 16'h0800);
    run(3);
    seen = 5'h00;
    wr_reg(A_BMC, 16'h0000);
    run(3);
    check(seen[0], 1'h1);
    seen = 5'h00;
    lfail = 1'h1;
    run(1);
    lfail = 1'h0;
    run(4);
    check(seen[0], 1'h1);
    wr_reg(A_BMC, 16'h0200);
    run(3);
    seen = 5'h00;
    lfail = 1'h1;
    run(1);
    lfail = 1'h0;
    run(4);
    check(seen[0], 1'h0);
    s_en = 1'h0;
    for (int c = 3; c >= 0; c--) begin
      {s_hi, s_lo} = c[1:0];
      wr_reg(A_BMC, 16'h8000);
      run(4);
      check({s100, fd}, c[1:0]);
      if (c == 1) begin
        tx_en = 1'h1;
        run(3);
        check(crs, 1'h0);
        seen = 5'h00;
        burst_run(1'h0, 5 + $urandom_range(3));
        check(seen[3:2], 2'h2);
        rx_end = 1'h1;
        tx_en = 1'h0;
        run(4);
        rx_end = 1'h0;
      end
    end
    seen = 5'h00;
    burst_run(1'h0, 5 + $urandom_range(3));
    check(seen[3:2], 2'h2);
    check(pol, 1'h0);
    rx_end = 1'h1;
    run(4);
    check(crs, 1'h0);
    rx_end = 1'h0;
    tx_en = 1'h1;
    run(2);
    check(crs, 1'h1);
    check(txo, 1'h1);
    seen = 5'h00;
    burst_run(1'h0, 6);
    check({seen[4], seen[2]}, 2'h3);
    rx_end = 1'h1;
    tx_en = 1'h0;
    run(4);
    rx_end = 1'h0;
    seen = 5'h00;
    burst_run(1'h0, 2);
    check(seen[3], 1'h0);
    rx_end = 1'h1;
    run(4);
    rx_end = 1'h0;
    burst_run(1'h1, 6);
    check(pol, 1'h1);
    rx_end = 1'h1;
    run(4);
    rx_end = 1'h0;
    for (int i = 0; i < 3; i++) begin
      lim = (i == 0) ? 32 : 20;
      wr_reg(A_SW3, 16'h0001 << i);
      seen = 5'h00;
      pulse(i, lim - 1);
      run(1100);
      pulse(i, lim - 1);
      run(4);
      check(seen[1], 1'h0);
      pulse(i, 2 * lim);
      run(4);
      check(seen[1], 1'h1);
      wr_reg(A_SW3, 16'h0001 << ((i + 1) % 4));
      run(1100);
      seen = 5'h00;
      pulse(i, 2 * lim);
      run(4);
      check(seen[1], 1'h0);
    end
    wr_reg(A_SW3, 16'h0008);
    seen = 5'h00;
    eloss = 1'h1;
    run(6);
    check(seen[1], 1'h1);
    eloss = 1'h0;
    wr_reg(A_SW3, 16'h0007);
    seen = 5'h00;
    eloss = 1'h1;
    run(6);
    check(seen[1], 1'h0);
    eloss = 1'h0;
    wr_reg(A_ADV, 16'h8001);
    rd_reg(A_ADV, 16'h8001, 16'hFFFF);
    // null pages go out until the partner's page has its top bit clear
    for (int k = 0; k < 3; k++) begin
      v = (k < 2) ? (16'h8000 | 16'($urandom)) : (16'h7FFF & 16'($urandom));
      wr_reg(A_NPT, 16'h2001);
      run(8);
      plc_partner_i.send_page(v);
      run(2);
      rd_reg(A_EXP, 16'h0002, 16'h0002);
      rd_reg(A_LNP, v, 16'hFFFF);
      rd_reg(A_EXP, 16'h0000, 16'h0002);
    end
    lat = 8'h28;
    wr_reg(A_NPT, 16'h1234);
    run(2);
    check({psend, pdata}, {1'h1, 16'h1234});
    plc_partner_i.send_page(~v);
    run(2);
    rd_reg(A_LNP, v, 16'hFFFF);
    run(50);
    check(psend, 1'h0);
    finish_test();
  end
endmodule // testbench
